// ---- core/arpt_timer.sv ----
// 12-bit autoreload timer with one modulated output and an output compare.
// Assumes an AHB-Lite master, lite-timer tick and power-mode levels synchronous to hclk.
// How it works
// (RQ1) 12-bit up-counter ticks on selected clock, restarts from reload on overflow.
// (RQ2) Clock select: 00 off, 01 lite tick, 10 cpu clock, 11 reserved.
// (RQ3) New clock selection applies only after the next overflow; applied at once while off or reserved is active.
// (RQ4) Counter resets to zero and counts from zero once clocked.
// (RQ5) Overflow sets flag; reading control/status register clears it.
// (RQ6) Overflow flag stays high one counter clock period.
// (RQ7) Overflow interrupt only while its enable is set; reset clears enable.
// (RQ8) Compare interrupt enable gates compare flag interrupt; reset clears it.
// (RQ9) Modulation overflow: reload counter, load active duty, output high.
// (RQ10) Modulation mode: output low when counter equals active duty.
// (RQ11) Polarity bit inverts modulated output.
// (RQ12) Output enable drives pin as push-pull modulated output.
// (RQ13) Period is 4096 minus reload ticks, one tick resolution.
// (RQ14) Software keeps duty above reload; reload at most 4094.
// (RQ15) Duty high written first; compare suspended until low byte written.
// (RQ16) Compare mode: written duty takes effect immediately.
// (RQ17) Counter equal compare value sets compare flag, interrupt if enabled.
// (RQ18) Compare inactive while compare value is zero.
// (RQ19) Each overflow copies duty into shadow; modulation uses shadow, compare uses duty.
// (RQ20) Software reads counter low byte first, then high byte.
// (RQ21) Slow mode divides input clock by 32; wait no effect; halt stops.
// (RQ22) Active-halt stops timer unless lite tick selected and overflow interrupt enabled.
// (RQ23) Overflow wakes from wait, active-halt with lite tick; compare wakes wait only.
// (RQ24) Compare flag set on match; reading output control/status clears it.
// (RQ25) Overflow is advancing from 4095; counter reloads instead of wrapping.
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module arpt_timer
    import arpt_pkg::*;
#(
    parameter int CW = 12
) (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Tick and power modes
    input  wire logic        lite_tick,
    input  wire logic        slow_mode,
    input  wire logic        wait_mode,
    input  wire logic        active_halt,
    input  wire logic        full_halt,
    // Interrupts and wake
    output logic             ovf_irq,
    output logic             cmp_irq,
    output logic             wake_req,
    // Modulated output pin
    output logic             modulated_output,
    output logic             modulated_output_oe
);
    localparam logic [CW-1:0] ALL_ONES = {CW{1'b1}};

    // Timer datapath registers
    logic [CW-1:0] counter_value_r;
    logic [CW-1:0] reload_value_r;
    logic [CW-1:0] duty_value_r;
    // Duty in force for the running period
    logic [CW-1:0] shadow_r;
    // Requested and active clock selections
    logic [1:0]    clksel_req_r;
    logic [1:0]    clksel_act_r;
    // Status flags, enables and pin state
    logic          overflow_flag_r;
    logic          overflow_irq_enable_r;
    logic          compare_irq_enable_r;
    logic          compare_flag_r;
    logic          polarity_r;
    logic          output_enable_bit_r;
    logic          cmp_locked_r;
    logic          pwm_level_r;
    // Divider state for slow mode
    logic [4:0]    slow_cnt_r;

    // Bus phase capture
    logic          dp_wr_r;
    logic          dp_rd_r;
    logic [7:0]    dp_idx_r;
    logic          ap_valid;
    logic          wr_en;
    logic [7:0]    wbyte;

    assign ap_valid  = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;   // zero wait state
    assign hresp     = 1'b0;
    assign wr_en     = dp_wr_r && clk_en;
    assign wbyte     = hwdata[7:0];

    // Address phase latch. Only the word index is kept: each register
    // is one byte in bits 7:0, so hsize and byte lanes are ignored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r  <= 1'b0;
            dp_rd_r  <= 1'b0;
            dp_idx_r <= 8'h00;
        end else if (clk_en) begin
            dp_wr_r  <= ap_valid && hwrite;
            dp_rd_r  <= ap_valid && !hwrite;
            dp_idx_r <= haddr[9:2];
        end
    end

    // Counter clock qualification and power modes
    logic raw_tick;
    logic slow_tick;
    logic halted;
    logic cnt_tick;
    logic overflow;
    always_comb begin
        unique case (arpt_clksel_t'(clksel_act_r))
            // (RQ2) clock select decode
            ARPT_CLK_LITE: raw_tick = lite_tick;
            ARPT_CLK_CPU:  raw_tick = 1'b1;
            default:       raw_tick = 1'b0;
        endcase
    end
    // (RQ21) slow divides by 32; wait ignored
    assign slow_tick = raw_tick && (!slow_mode || slow_cnt_r == 5'(SLOW_DIV - 1));
    // Lite tick with overflow interrupt on: the only setting
    // that keeps counting through active-halt
    logic lite_keepalive;
    assign lite_keepalive = clksel_act_r == ARPT_CLK_LITE && overflow_irq_enable_r;
    // (RQ22) active-halt exception for lite tick
    assign halted   = full_halt || (active_halt && !lite_keepalive);
    // Wait mode left out on purpose: the timer must keep
    // running so that its interrupts can end the wait
    assign cnt_tick = clk_en && slow_tick && !halted;
    // (RQ25) overflow on leaving all-ones
    assign overflow = cnt_tick && counter_value_r == ALL_ONES;

    // Slow mode prescaler. It counts qualifying input ticks, so the
    // divide applies to the selected clock, not to hclk.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            slow_cnt_r <= 5'h00;
        else if (clk_en && raw_tick && slow_mode && !halted)
            slow_cnt_r <= slow_cnt_r + 5'h01;
    end

    // Counter. Overflow is taken on leaving all-ones, so a period is
    // 4096 minus the reload; a reload of 4095 leaves no room for a duty
    // value above it, hence software keeps the reload at 4094 or less.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // (RQ4) starts at zero
            counter_value_r <= COUNTER_RESET;
        end else if (overflow) begin
            // (RQ1) reload on overflow
            counter_value_r <= reload_value_r;
        end else if (cnt_tick) begin
            // (RQ13) period 4096 minus reload
            counter_value_r <= counter_value_r + 1'b1;
        end
    end

    // A stopped counter never overflows, so a selection that stops it
    // (off or the reserved code) gives way at once; otherwise only a
    // reset could start the timer again.
    logic sel_stopped;
    assign sel_stopped = clksel_act_r == ARPT_CLK_OFF || clksel_act_r == ARPT_CLK_RSVD;

    // Clock selection, applied at overflow or from the stopped state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clksel_act_r <= 2'b00;
        end else if (clk_en && (overflow || sel_stopped)) begin
            // (RQ3) change waits for overflow
            clksel_act_r <= clksel_req_r;
        end
    end

    // Flag values handed out by the read now in its data phase. A flag
    // set on the address-phase edge was not seen by software and must
    // survive the clear, or the event would be lost unreported.
    logic ovf_seen_r;
    logic cmp_seen_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_seen_r <= 1'b0;
            cmp_seen_r <= 1'b0;
        end else if (clk_en) begin
            ovf_seen_r <= overflow_flag_r;
            cmp_seen_r <= compare_flag_r;
        end
    end

    // Overflow flag: held one counter clock period, cleared by status read
    logic ovf_clr;
    assign ovf_clr = dp_rd_r && clk_en && ovf_seen_r &&
                     dp_idx_r == IDX_TIMER_CONTROL_STATUS;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            overflow_flag_r <= 1'b0;
        else if (overflow)
            // (RQ5) set wins over read clear
            // Overflow is itself a tick, so the tick clear below
            // cannot cut the flag short in its first cycle.
            overflow_flag_r <= 1'b1;
        else if (ovf_clr || cnt_tick)
            // (RQ6) lasts one counter tick
            overflow_flag_r <= 1'b0;
    end

    // Control register writes. Reserved bits are not stored and read
    // back as zero; the overflow flag bit ignores writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clksel_req_r          <= 2'b00;
            overflow_irq_enable_r <= 1'b0;
            compare_irq_enable_r  <= 1'b0;
            polarity_r            <= 1'b0;
            output_enable_bit_r   <= 1'b0;
            reload_value_r        <= COUNTER_RESET;
        end else if (wr_en) begin
            unique case (dp_idx_r)
                IDX_TIMER_CONTROL_STATUS: begin
                    clksel_req_r          <= wbyte[CLK_SEL_LSB +: 2];
                    // (RQ7) overflow enable
                    overflow_irq_enable_r <= wbyte[OVF_IE_BIT];
                    // (RQ8) compare enable
                    compare_irq_enable_r  <= wbyte[CMP_IE_BIT];
                end
                IDX_RELOAD_VALUE_HIGH:     reload_value_r[CW-1:8] <= wbyte[CW-9:0];
                IDX_RELOAD_VALUE_LOW:      reload_value_r[7:0]    <= wbyte;
                IDX_OUTPUT_ENABLE_REG:     output_enable_bit_r    <= wbyte[OUT_EN_BIT];
                IDX_OUTPUT_CONTROL_STATUS: polarity_r             <= wbyte[POLARITY_BIT];
                default: ;
            endcase
        end
    end

    // Duty registers and compare lock. The lock opens only on the low
    // byte, so a high byte written just before a match can cost one
    // compare; software updates duty right after an overflow.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            duty_value_r <= COUNTER_RESET;
            cmp_locked_r <= 1'b0;
        end else if (wr_en && dp_idx_r == IDX_DUTY_VALUE_HIGH) begin
            // (RQ15) high byte locks compare
            duty_value_r[CW-1:8] <= wbyte[CW-9:0];
            cmp_locked_r         <= 1'b1;
        end else if (wr_en && dp_idx_r == IDX_DUTY_VALUE_LOW) begin
            // (RQ16) takes effect at once
            duty_value_r[7:0] <= wbyte;
            cmp_locked_r      <= 1'b0;
        end
    end

    // Copied even with only the high byte rewritten, so one period may
    // run on a mixed duty value until the low byte follows.
    // (RQ19) shadow copy at every overflow
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            shadow_r <= COUNTER_RESET;
        else if (overflow)
            shadow_r <= duty_value_r;
    end

    // Compare source and match. Qualified by a tick, so a stopped
    // counter resting on the compare value sets the flag only once.
    logic [CW-1:0] cmp_value;
    logic          match;
    assign cmp_value = output_enable_bit_r ? shadow_r : duty_value_r;
    // (RQ18) zero compare value inactive
    assign match = clk_en && !cmp_locked_r && cmp_value != COUNTER_RESET &&
                   counter_value_r == cmp_value && cnt_tick;

    // Compare flag, cleared by output status read; set wins
    logic cmp_clr;
    assign cmp_clr = dp_rd_r && clk_en && cmp_seen_r &&
                     dp_idx_r == IDX_OUTPUT_CONTROL_STATUS;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            compare_flag_r <= 1'b0;
        else if (match)
            // (RQ17) match sets flag
            compare_flag_r <= 1'b1;
        else if (cmp_clr)
            // (RQ24) read clears flag
            compare_flag_r <= 1'b0;
    end

    // Waveform level. Overflow wins over a match in the same tick, so a
    // duty of 4095 keeps the level high for the whole period.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            pwm_level_r <= 1'b0;
        else if (overflow)
            // (RQ9) high at overflow
            pwm_level_r <= 1'b1;
        else if (match && output_enable_bit_r)
            // (RQ10) low at duty match
            pwm_level_r <= 1'b0;
    end

    // Interrupt and wake requests ahead of the output flops
    logic ovf_req;
    logic cmp_req;
    logic ovf_wake;
    logic cmp_wake;
    // (RQ7) overflow request needs its enable
    assign ovf_req  = overflow_flag_r && overflow_irq_enable_r;
    // (RQ8) compare request needs its enable
    assign cmp_req  = compare_flag_r && compare_irq_enable_r;
    // Overflow ends wait, and active-halt only on the lite tick;
    // a compare ends wait only
    assign ovf_wake = ovf_req && (wait_mode || (active_halt && clksel_act_r == ARPT_CLK_LITE));
    assign cmp_wake = cmp_req && wait_mode;

    // Pin and interrupt outputs, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            modulated_output    <= 1'b0;
            modulated_output_oe <= 1'b0;
            ovf_irq             <= 1'b0;
            cmp_irq             <= 1'b0;
            wake_req            <= 1'b0;
        end else if (clk_en) begin
            // (RQ11) polarity inverts
            modulated_output    <= (pwm_level_r ^ polarity_r) && output_enable_bit_r;
            // (RQ12) push-pull drive when enabled
            modulated_output_oe <= output_enable_bit_r;
            ovf_irq             <= ovf_req;
            cmp_irq             <= cmp_req;
            // (RQ23) wake sources per mode
            wake_req            <= ovf_wake || cmp_wake;
        end
    end

    // Read data, registered at the address-phase edge so it stands for
    // the whole data phase. A read right behind a write to the same
    // register sees the old byte; leave one idle cycle between them.
    // A carry between the two counter byte reads can tear the value.
    // (RQ20) no latch: software reads low byte then high byte
    logic [7:0] rbyte;
    always_comb begin
        rbyte = REG_RESET;
        unique case (haddr[9:2])
            IDX_TIMER_CONTROL_STATUS:  rbyte = {3'b000, clksel_req_r, overflow_flag_r,
                                                overflow_irq_enable_r, compare_irq_enable_r};
            IDX_COUNTER_VALUE_HIGH:    rbyte = {4'h0, counter_value_r[CW-1:8]};
            IDX_COUNTER_VALUE_LOW:     rbyte = counter_value_r[7:0];
            IDX_RELOAD_VALUE_HIGH:     rbyte = {4'h0, reload_value_r[CW-1:8]};
            IDX_RELOAD_VALUE_LOW:      rbyte = reload_value_r[7:0];
            IDX_OUTPUT_ENABLE_REG:     rbyte = {7'h00, output_enable_bit_r};
            IDX_OUTPUT_CONTROL_STATUS: rbyte = {6'h00, polarity_r, compare_flag_r};
            IDX_DUTY_VALUE_HIGH:       rbyte = {4'h0, duty_value_r[CW-1:8]};
            IDX_DUTY_VALUE_LOW:        rbyte = duty_value_r[7:0];
            default:                   rbyte = REG_RESET;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (clk_en && ap_valid && !hwrite)
            hrdata <= {24'h000000, rbyte};
    end
endmodule
`default_nettype wire

// ---- core/arpt_pkg.sv ----
// Package for the autoreload modulation timer: register map, fields, resets.
// Assumes an AHB-Lite slave with word-aligned byte registers in the low bits.
package arpt_pkg;
    // Register indices (printed offsets are not word aligned); byte address = 4 * index
    localparam logic [7:0] IDX_TIMER_CONTROL_STATUS  = 8'h0d;
    localparam logic [7:0] IDX_COUNTER_VALUE_HIGH    = 8'h0e;
    localparam logic [7:0] IDX_COUNTER_VALUE_LOW     = 8'h0f;
    localparam logic [7:0] IDX_RELOAD_VALUE_HIGH     = 8'h10;
    localparam logic [7:0] IDX_RELOAD_VALUE_LOW      = 8'h11;
    localparam logic [7:0] IDX_OUTPUT_ENABLE_REG     = 8'h12;
    localparam logic [7:0] IDX_OUTPUT_CONTROL_STATUS = 8'h13;
    localparam logic [7:0] IDX_DUTY_VALUE_HIGH       = 8'h17;
    localparam logic [7:0] IDX_DUTY_VALUE_LOW        = 8'h18;
    // Field positions
    localparam int CLK_SEL_LSB       = 3;
    localparam int OVF_FLAG_BIT      = 2;
    localparam int OVF_IE_BIT        = 1;
    localparam int CMP_IE_BIT        = 0;
    localparam int POLARITY_BIT      = 1;
    localparam int CMP_FLAG_BIT      = 0;
    localparam int OUT_EN_BIT        = 0;
    // Reset values
    localparam logic [11:0] COUNTER_RESET = 12'h000;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    // Slow mode divides the counter input clock
    localparam int          SLOW_DIV      = 32;
    // Counter clock selections
    typedef enum logic [1:0] {
        ARPT_CLK_OFF  = 2'b00,
        ARPT_CLK_LITE = 2'b01,
        ARPT_CLK_CPU  = 2'b10,
        ARPT_CLK_RSVD = 2'b11
    } arpt_clksel_t;
endpackage

// ---- testbench/arpt_timer_chk.sv ----
// Port-level checker for the autoreload timer.
// Assumes one clock and the bind below; sees only the timer ports.
`timescale 1ns/1ps
`default_nettype none
module arpt_timer_chk #(
    parameter int CW = 12
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Modes and outputs
    input wire logic        wait_mode,
    input wire logic        full_halt,
    input wire logic        ovf_irq,
    input wire logic        cmp_irq,
    input wire logic        wake_req,
    input wire logic        modulated_output,
    input wire logic        modulated_output_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_any;
    // Taken read address phase
    assign rd_any = hsel && hready && htrans[1] && !hwrite && clk_en;
    property p_rst; $rose(hresetn) |-> !ovf_irq && !cmp_irq && !modulated_output && !modulated_output_oe; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_oe; !modulated_output_oe |-> !modulated_output; endproperty
    a_oe: assert property (p_oe) else $error("pin high while not driven");
    property p_halt; full_halt && $past(full_halt) && $past(full_halt, 2) |-> $stable(modulated_output) && !$rose(ovf_irq); endproperty
    a_halt: assert property (p_halt) else $error("timer moved in halt");
    property p_ovf_clr; rd_any && haddr == 32'h0000_0034 && ovf_irq |-> ##[2:4] !ovf_irq; endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag not cleared by read");
    property p_cmp_clr; rd_any && haddr == 32'h0000_004c && cmp_irq |-> ##[2:4] !cmp_irq; endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("compare flag not cleared by read");
    property p_wake_o; wait_mode && ovf_irq |-> ##[0:2] wake_req; endproperty
    a_wake_o: assert property (p_wake_o) else $error("no wake on overflow");
    property p_wake_c; wait_mode && cmp_irq |-> ##[0:2] wake_req; endproperty
    a_wake_c: assert property (p_wake_c) else $error("no wake on compare");
    property p_bus; hreadyout && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus answer not ready okay");
endmodule
bind arpt_timer arpt_timer_chk #(.CW(CW)) u_chk (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .wait_mode, .full_halt, .ovf_irq, .cmp_irq, .wake_req, .modulated_output, .modulated_output_oe);
`default_nettype wire

// ---- testbench/arpt_pin_model.sv ----
// External load on the modulated pin: pull-down and waveform meter.
// Assumes it shares the timer clock.
`timescale 1ns/1ps
`default_nettype none
module arpt_pin_model (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Pin driver
    input  wire logic        pin,
    input  wire logic        pin_oe,
    // Last period and high time, in cycles
    output logic      [15:0] per_len,
    output logic      [15:0] hi_len
);
    logic        line, prev;
    logic [15:0] cnt, hcnt;
    assign line = pin_oe ? pin : 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev <= 1'b0;
            cnt <= '0;
            hcnt <= '0;
            per_len <= '0;
            hi_len <= '0;
        end else begin
            prev <= line;
            cnt <= cnt + 16'h0001;
            if (line)
                hcnt <= hcnt + 16'h0001;
            if (line && !prev) begin
                per_len <= cnt;
                cnt <= 16'h0001;
                hcnt <= 16'h0001;
            end
            if (!line && prev)
                hi_len <= hcnt;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/arpt_timer_tb.sv ----
// Self-checking bench for the autoreload timer.
// Assumes the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module arpt_timer_tb;
    import arpt_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, lite_tick, clk_en;
    logic        slow_mode, wait_mode, active_halt, full_halt;
    logic        hreadyout, hresp, ovf_irq, cmp_irq, wake_req, pin, pin_oe;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] per_len, hi_len;
    logic [11:0] r, d;
    logic [7:0]  rv;
    int          err_count, check_count, seed, tick_cnt;
    // Clock
    always #12.5 hclk = ~hclk;
    // Lite tick every 200 cycles
    always @(posedge hclk) begin
        tick_cnt <= (tick_cnt == 199) ? 0 : tick_cnt + 1;
        lite_tick <= (tick_cnt == 199);
    end
    arpt_timer #(.CW(12)) DUT (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lite_tick, .slow_mode, .wait_mode, .active_halt,
        .full_halt, .ovf_irq, .cmp_irq, .wake_req, .modulated_output(pin), .modulated_output_oe(pin_oe));
    arpt_pin_model PM (.hclk, .hresetn, .pin, .pin_oe, .per_len, .hi_len);
    task automatic complete_run;
        $display("Checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Waits on ready (sel 2) or an interrupt line, bounded
    task automatic wait_on(input int sel, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            if (n > lim) begin
                err_count++;
                complete_run();
            end
        end while ((sel == 2 ? hreadyout : sel == 1 ? cmp_irq : ovf_irq) !== 1'b1);
    endtask
    // Single word transfer; read data taken at the data-phase edge
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_on(2, 50);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_on(2, 50);
        rv = hrdata[7:0];
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        chk($sformatf("reg %h", idx), {24'h0, exp}, {24'h0, rv});
    endtask
    task automatic setup(input logic [11:0] rl, input logic [11:0] dt);
        bus(IDX_RELOAD_VALUE_HIGH, 1'b1, {4'h0, rl[11:8]});
        bus(IDX_RELOAD_VALUE_LOW, 1'b1, rl[7:0]);
        bus(IDX_DUTY_VALUE_HIGH, 1'b1, {4'h0, dt[11:8]});
        bus(IDX_DUTY_VALUE_LOW, 1'b1, dt[7:0]);
    endtask
    // Counts cycles with the chosen interrupt high
    task automatic quiet(input bit c, input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(posedge hclk);
            if ((c ? cmp_irq : ovf_irq) !== 1'b0)
                hits++;
        end
        chk("irq quiet", 0, hits);
    endtask
    initial begin
        {hclk, hresetn, hsel, hwrite, slow_mode, wait_mode, active_halt, full_halt} = '0;
        {htrans, haddr, hwdata, err_count, check_count} = '0;
        clk_en = 1'b1;
        hsize = 3'b010;
        seed = 32'haf78;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, unmapped slots, read-only write
        for (int i = 8'h0d; i <= 8'h18; i++)
            rdc(i[7:0], 8'h00);
        bus(IDX_COUNTER_VALUE_LOW, 1'b1, 8'hff);
        rdc(IDX_COUNTER_VALUE_LOW, 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 12'd4000 : 12'd3900 + 12'($random(seed) & 63);
            d = (i == 0) ? r + 12'd1 : r + 12'd1 + 12'($random(seed) & 31);
            setup(r, d);
            bus(IDX_OUTPUT_CONTROL_STATUS, 1'b1, {6'h0, i[0], 1'b0});
            bus(IDX_OUTPUT_ENABLE_REG, 1'b1, 8'h01);
            bus(IDX_TIMER_CONTROL_STATUS, 1'b1, 8'h10);
            // First pass climbs from zero before its first overflow
            repeat ((i == 0 ? 4096 : 200) + 3 * (4096 - r) + 20) @(posedge hclk);
            chk("period", 32'(4096 - r), {16'h0, per_len});
            chk("high", i[0] ? 32'(4095 - d) : 32'(d - r + 1), {16'h0, hi_len});
        end
        // Slow mode stretches each tick
        setup(12'd4090, 12'd4093);
        bus(IDX_OUTPUT_CONTROL_STATUS, 1'b1, 8'h00);
        repeat (200) @(posedge hclk);
        slow_mode <= 1'b1;
        repeat (800) @(posedge hclk);
        chk("slow period", 32'd192, {16'h0, per_len});
        full_halt <= 1'b1;
        repeat (40) @(posedge hclk);
        full_halt <= 1'b0;
        slow_mode <= 1'b0;
        // Clock off only after the next overflow
        bus(IDX_TIMER_CONTROL_STATUS, 1'b1, 8'h00);
        repeat (20) @(posedge hclk);
        rdc(IDX_COUNTER_VALUE_LOW, 8'hfa);
        rdc(IDX_COUNTER_VALUE_HIGH, 8'h0f);
        wait_mode <= 1'b1;
        bus(IDX_TIMER_CONTROL_STATUS, 1'b1, 8'h0a);
        wait_on(0, 3000);
        rdc(IDX_TIMER_CONTROL_STATUS, 8'h0e);
        rdc(IDX_TIMER_CONTROL_STATUS, 8'h0a);
        bus(IDX_TIMER_CONTROL_STATUS, 1'b1, 8'h08);
        quiet(1'b0, 1300);
        // Compare mode, pin released
        bus(IDX_OUTPUT_ENABLE_REG, 1'b1, 8'h00);
        setup(12'd3000, 12'd3500);
        bus(IDX_TIMER_CONTROL_STATUS, 1'b1, 8'h11);
        wait_on(1, 4000);
        rdc(IDX_OUTPUT_CONTROL_STATUS, 8'h01);
        rdc(IDX_OUTPUT_CONTROL_STATUS, 8'h00);
        bus(IDX_DUTY_VALUE_HIGH, 1'b1, 8'h0e);
        quiet(1'b1, 1200);
        bus(IDX_DUTY_VALUE_LOW, 1'b1, 8'hac);
        wait_on(1, 1200);
        rdc(IDX_OUTPUT_CONTROL_STATUS, 8'h01);
        setup(12'd3000, 12'd0);
        rdc(IDX_OUTPUT_CONTROL_STATUS, 8'h00);
        quiet(1'b1, 1200);
        complete_run();
    end
endmodule
`default_nettype wire
